// ==== src/pioxb_pkg.sv ====
// Purpose: Shared constants of the port I/O priority crossbar
// Assumes: 22 pins, pins 0..19 reachable by the crossbar
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
package pioxb_pkg;
	localparam int NPIN      = 22;
	localparam int NXPIN     = 20;
	localparam int NSIG      = 24;
	localparam int NPORT     = 4;
	localparam int AW        = 6;

	// Register byte offsets
	localparam logic [5:0] OFS_PORT    = 6'h00;
	localparam logic [5:0] OFS_INMODE  = 6'h04;
	localparam logic [5:0] OFS_OUTMODE = 6'h08;
	localparam logic [5:0] OFS_SKIP    = 6'h0C;
	localparam logic [5:0] OFS_DRIVE   = 6'h10;
	localparam logic [5:0] OFS_ROUTE0  = 6'h14;
	localparam logic [5:0] OFS_ROUTE1  = 6'h18;
	localparam logic [5:0] OFS_ROUTE2  = 6'h1C;
	localparam logic [5:0] OFS_EXTINT  = 6'h20;
	localparam logic [5:0] OFS_ASSIGN  = 6'h24;

	// Reset values, and the mask of writable route register 2 bits
	localparam logic [21:0] INMODE_RST  = 22'h3F_FFFF;
	localparam logic [21:0] OUTMODE_RST = 22'h00_0000;
	localparam logic [21:0] LATCH_RST   = 22'h3F_FFFF;
	localparam logic [19:0] SKIP_RST    = 20'h0_0000;
	localparam logic [3:0]  DRIVE_RST   = 4'hF;
	localparam logic [7:0]  ROUTE0_RST  = 8'h00;
	localparam logic [5:0]  ROUTE1_RST  = 6'h00;
	localparam logic [7:0]  ROUTE2_RST  = 8'h00;
	localparam logic [7:0]  ROUTE2_MASK = 8'hC7;

	// Field positions
	localparam int R0_UARTA  = 0;
	localparam int R0_SPI    = 1;
	localparam int R0_SMB    = 2;
	localparam int R0_CMPA   = 3;
	localparam int R0_CMPAA  = 4;
	localparam int R0_CMPB   = 5;
	localparam int R0_CMPBA  = 6;
	localparam int R0_SYSCK  = 7;
	localparam int R1_ECI    = 2;
	localparam int R1_TMRA   = 3;
	localparam int R1_TMRB   = 4;
	localparam int R1_TMRC   = 5;
	localparam int R2_UARTB  = 0;
	localparam int R2_RTS    = 1;
	localparam int R2_CTS    = 2;
	localparam int R2_XBAREN = 6;
	localparam int R2_PUDIS  = 7;
	localparam int EXT_A_LSB = 0;
	localparam int EXT_B_LSB = 4;

	// Fixed pins of the primary UART, and the first pin of ports 1 to 3
	localparam logic [4:0] UART_TX_PIN = 5'd4;
	localparam logic [4:0] UART_RX_PIN = 5'd5;
	localparam int PORT1_BASE = 8;
	localparam int PORT2_BASE = 16;
	localparam int PORT3_BASE = 20;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== src/pioxb_decoder.sv ====
// Purpose: Priority search placing enabled signals on free pins
// Assumes: Signal index is the priority, 0 highest
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module pioxb_decoder (
	// Requests
	input  wire logic [23:0]      sig_en,
	input  wire logic [19:0]      skip,
	// Placement
	output logic      [19:0]      pin_used,
	output logic      [19:0][4:0] pin_sig
);
	logic [19:0] occ;
	logic        found;

	always_comb begin
		occ = skip;
		pin_used = '0;
		pin_sig = '0;
		found = 1'b0;
		if (sig_en[0]) begin
			occ[pioxb_pkg::UART_TX_PIN] = 1'b1;
			occ[pioxb_pkg::UART_RX_PIN] = 1'b1;
			pin_used[pioxb_pkg::UART_TX_PIN] = 1'b1;
			pin_used[pioxb_pkg::UART_RX_PIN] = 1'b1;
			pin_sig[pioxb_pkg::UART_TX_PIN] = 5'd0;
			pin_sig[pioxb_pkg::UART_RX_PIN] = 5'd1;
		end
		for (int s = 2; s < pioxb_pkg::NSIG; s++) begin
			found = 1'b0;
			for (int p = 0; p < pioxb_pkg::NXPIN; p++) begin
				if (sig_en[s] && !found && !occ[p]) begin
					occ[p] = 1'b1;
					pin_used[p] = 1'b1;
					pin_sig[p] = 5'(s);
					found = 1'b1;
				end
			end
		end
	end
endmodule

// ==== src/pioxb_pad_cell.sv ====
// Purpose: Control of one pad: drivers, pullup, receiver
// Assumes: Output enable is active low
// Notes:   Combinational; the top registers every result
`timescale 1ns/1ps
module pioxb_pad_cell (
	// Configuration
	input  wire logic digital,
	input  wire logic push_pull,
	input  wire logic xbar_en,
	input  wire logic pullup_dis,
	// Data
	input  wire logic out_val,
	input  wire logic pad_in,
	// Pad controls
	output logic      pad_out,
	output logic      pad_oe_n,
	output logic      pullup_en,
	output logic      level
);
	logic drive_low;
	logic drive_high;

	always_comb begin
		// Analog pins keep both drivers off
		drive_low  = xbar_en && digital && !out_val;
		drive_high = xbar_en && digital && push_pull && out_val;
		pad_out    = out_val;
		pad_oe_n   = !(drive_low || drive_high);
		pullup_en  = digital && !pullup_dis && !drive_low;
		level      = digital && pad_in;
	end
endmodule

// ==== src/pioxb_top.sv ====
// Purpose: Port pin configuration and priority crossbar, AXI4-Lite regs
// Assumes: Pad and peripheral inputs are synchronous to aclk
// Notes:   Placement and pad controls settle one cycle after a change; crossbar pad outputs take two after a placement change
//
// Summary of operation
// - Input-mode bit 0 selects analog, 1 selects digital.
// - Analog pins: pullup, output driver and receiver all off.
// - Port read returns 0 for analog pins.
// - Port read returns pad level for digital pins.
// - Push-pull pins drive high for 1 and low for 0.
// - Open-drain pins drive only low, float for 1.
// - Pullup only while not driven low; global disable bit kills all.
// - Crossbar enable clear forces all output drivers off.
// - One drive-strength bit per port, high drive after reset.
// - Route-enable registers choose which signals are placed.
// - Fixed priority: primary UART first, secondary UART last.
// - Primary UART always on pins 4 and 5 of port 0.
// - Other signals go to lowest free, unskipped pin.
// - A placed pin is excluded for lower priority signals.
// - Skipped pins are treated as occupied.
// - Only pins P0.0 to P2.3 take crossbar signals.
// - Slave select takes a pin only in four-wire mode.
// - Crossbar owns output of shared pins; dedicated ones only read.
// - Latch writes do not alter crossbar pins; reads show pad.
// - Each external interrupt selects any port 0 pin.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pioxb_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [5:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [5:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Peripheral side
	input  wire logic [23:0] periph_out,
	input  wire logic        spi_four_wire,
	output logic [23:0]      periph_in,
	output logic             ext_int_a_level,
	output logic             ext_int_b_level,
	// Pads
	input  wire logic [21:0] pad_in,
	output logic [21:0]      pad_out,
	output logic [21:0]      pad_oe_n,
	output logic [21:0]      pad_pullup_en,
	output logic [21:0]      pad_high_drive
);
	typedef struct packed {
		logic [21:0]      latch;
		logic [21:0]      inmode;
		logic [21:0]      outmode;
		logic [19:0]      skip;
		logic [3:0]       drive;
		logic [7:0]       route0;
		logic [5:0]       route1;
		logic [7:0]       route2;
		logic [2:0]       int_a_sel;
		logic [2:0]       int_b_sel;
		logic [19:0]      pin_used;
		logic [19:0][4:0] pin_sig;
		logic             aw_got;
		logic             w_got;
		logic [5:0]       waddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             awready;
		logic             wready;
		logic [1:0]       bresp;
		logic             bvalid;
		logic             arready;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic             rvalid;
		logic [23:0]      periph_in;
		logic             ext_a;
		logic             ext_b;
		logic [21:0]      pad_out;
		logic [21:0]      pad_oe_n;
		logic [21:0]      pad_pullup_en;
		logic [21:0]      pad_high_drive;
	} pioxb_state_t;

	pioxb_state_t     st_reg;
	pioxb_state_t     st_next;
	logic [23:0]      sig_en;
	logic [19:0]      dec_used;
	logic [19:0][4:0] dec_sig;
	logic [21:0]      out_val;
	logic [21:0]      cell_out;
	logic [21:0]      cell_oe_n;
	logic [21:0]      cell_pu;
	logic [21:0]      level;

	// Signal enables in priority order
	always_comb begin
		sig_en[0]  = st_reg.route0[pioxb_pkg::R0_UARTA];
		sig_en[1]  = st_reg.route0[pioxb_pkg::R0_UARTA];
		sig_en[2]  = st_reg.route0[pioxb_pkg::R0_SPI];
		sig_en[3]  = st_reg.route0[pioxb_pkg::R0_SPI];
		sig_en[4]  = st_reg.route0[pioxb_pkg::R0_SPI];
		sig_en[5]  = st_reg.route0[pioxb_pkg::R0_SPI] && spi_four_wire;
		sig_en[6]  = st_reg.route0[pioxb_pkg::R0_SMB];
		sig_en[7]  = st_reg.route0[pioxb_pkg::R0_SMB];
		sig_en[8]  = st_reg.route0[pioxb_pkg::R0_CMPA];
		sig_en[9]  = st_reg.route0[pioxb_pkg::R0_CMPAA];
		sig_en[10] = st_reg.route0[pioxb_pkg::R0_CMPB];
		sig_en[11] = st_reg.route0[pioxb_pkg::R0_CMPBA];
		sig_en[12] = st_reg.route0[pioxb_pkg::R0_SYSCK];
		sig_en[13] = st_reg.route1[1:0] != 2'h0;
		sig_en[14] = st_reg.route1[1];
		sig_en[15] = st_reg.route1[1:0] == 2'h3;
		sig_en[16] = st_reg.route1[pioxb_pkg::R1_ECI];
		sig_en[17] = st_reg.route1[pioxb_pkg::R1_TMRA];
		sig_en[18] = st_reg.route1[pioxb_pkg::R1_TMRB];
		sig_en[19] = st_reg.route1[pioxb_pkg::R1_TMRC];
		sig_en[20] = st_reg.route2[pioxb_pkg::R2_UARTB];
		sig_en[21] = st_reg.route2[pioxb_pkg::R2_UARTB];
		sig_en[22] = st_reg.route2[pioxb_pkg::R2_RTS];
		sig_en[23] = st_reg.route2[pioxb_pkg::R2_CTS];
	end

	pioxb_decoder u_decoder (
		.sig_en   (sig_en),
		.skip     (st_reg.skip),
		.pin_used (dec_used),
		.pin_sig  (dec_sig)
	);

	genvar gp;
	generate
		for (gp = 0; gp < pioxb_pkg::NPIN; gp++) begin : g_pin
			if (gp < pioxb_pkg::NXPIN) begin : g_xbar
				// Crossbar pins ignore the latch once placed
				assign out_val[gp] = st_reg.pin_used[gp] ?
					periph_out[st_reg.pin_sig[gp]] :
					st_reg.latch[gp];
			end else begin : g_gpio
				assign out_val[gp] = st_reg.latch[gp];
			end
			pioxb_pad_cell u_cell (
				.digital    (st_reg.inmode[gp]),
				.push_pull  (st_reg.outmode[gp]),
				.xbar_en    (st_reg.route2[pioxb_pkg::R2_XBAREN]),
				.pullup_dis (st_reg.route2[pioxb_pkg::R2_PUDIS]),
				.out_val    (out_val[gp]),
				.pad_in     (pad_in[gp]),
				.pad_out    (cell_out[gp]),
				.pad_oe_n   (cell_oe_n[gp]),
				.pullup_en  (cell_pu[gp]),
				.level      (level[gp])
			);
		end
	endgenerate

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction

	function automatic logic [31:0] read_reg(input pioxb_state_t s,
		input logic [21:0] lvl, input logic [5:0] a);
		logic [31:0] d;
		d = '0;
		case ({a[5:2], 2'b00})
			pioxb_pkg::OFS_PORT:    d[21:0] = lvl;
			pioxb_pkg::OFS_INMODE:  d[21:0] = s.inmode;
			pioxb_pkg::OFS_OUTMODE: d[21:0] = s.outmode;
			pioxb_pkg::OFS_SKIP:    d[19:0] = s.skip;
			pioxb_pkg::OFS_DRIVE:   d[3:0]  = s.drive;
			pioxb_pkg::OFS_ROUTE0:  d[7:0]  = s.route0;
			pioxb_pkg::OFS_ROUTE1:  d[5:0]  = s.route1;
			pioxb_pkg::OFS_ROUTE2:  d[7:0]  = s.route2;
			pioxb_pkg::OFS_EXTINT: begin
				d[pioxb_pkg::EXT_A_LSB +: 3] = s.int_a_sel;
				d[pioxb_pkg::EXT_B_LSB +: 3] = s.int_b_sel;
			end
			pioxb_pkg::OFS_ASSIGN:  d[19:0] = s.pin_used;
			default:                d = '0;
		endcase
		return d;
	endfunction

	function automatic logic mapped(input logic [5:0] a);
		return {a[5:2], 2'b00} <= pioxb_pkg::OFS_ASSIGN;
	endfunction

	always_comb begin
		logic [31:0] m;
		logic [31:0] v;
		logic [7:0]  pidx;
		m = '0;
		v = '0;
		pidx = '0;
		st_next = st_reg;

		// Placement from current settings
		st_next.pin_used = dec_used;
		st_next.pin_sig  = dec_sig;

		// Write channel: address and data in either order
		if (awvalid && st_reg.awready) begin
			st_next.aw_got = 1'b1;
			st_next.waddr  = awaddr;
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = wdata;
			st_next.wstrb = wstrb;
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_next.aw_got && st_next.w_got && !st_reg.bvalid) begin
			m = lane_mask(st_next.wstrb);
			v = st_next.wdata & m;
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = mapped(st_next.waddr) ?
				pioxb_pkg::RESP_OKAY : pioxb_pkg::RESP_SLVERR;
			case ({st_next.waddr[5:2], 2'b00})
				pioxb_pkg::OFS_PORT:
					st_next.latch = (st_reg.latch & ~m[21:0]) | v[21:0];
				pioxb_pkg::OFS_INMODE:
					st_next.inmode = (st_reg.inmode & ~m[21:0]) | v[21:0];
				pioxb_pkg::OFS_OUTMODE:
					st_next.outmode = (st_reg.outmode & ~m[21:0]) | v[21:0];
				pioxb_pkg::OFS_SKIP:
					st_next.skip = (st_reg.skip & ~m[19:0]) | v[19:0];
				pioxb_pkg::OFS_DRIVE:
					st_next.drive = (st_reg.drive & ~m[3:0]) | v[3:0];
				pioxb_pkg::OFS_ROUTE0:
					st_next.route0 = (st_reg.route0 & ~m[7:0]) | v[7:0];
				pioxb_pkg::OFS_ROUTE1:
					st_next.route1 = (st_reg.route1 & ~m[5:0]) | v[5:0];
				pioxb_pkg::OFS_ROUTE2:
					st_next.route2 = ((st_reg.route2 & ~m[7:0]) | v[7:0])
						& pioxb_pkg::ROUTE2_MASK;
				pioxb_pkg::OFS_EXTINT: begin
					if (st_next.wstrb[0]) begin
						st_next.int_a_sel =
							st_next.wdata[pioxb_pkg::EXT_A_LSB +: 3];
						st_next.int_b_sel =
							st_next.wdata[pioxb_pkg::EXT_B_LSB +: 3];
					end
				end
				default: ;
			endcase
		end
		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready  = !st_next.w_got && !st_next.bvalid;

		// Read channel
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = read_reg(st_reg, level, araddr);
			st_next.rresp  = mapped(araddr) ?
				pioxb_pkg::RESP_OKAY : pioxb_pkg::RESP_SLVERR;
		end
		st_next.arready = !st_next.rvalid;

		// Peripheral inputs follow the pad of their placed pin
		st_next.periph_in = '1;
		for (int p = 0; p < pioxb_pkg::NXPIN; p++) begin
			if (st_reg.pin_used[p]) begin
				st_next.periph_in[st_reg.pin_sig[p]] = level[p];
			end
		end

		// External interrupts only observe port 0 pins
		st_next.ext_a = level[st_reg.int_a_sel];
		st_next.ext_b = level[st_reg.int_b_sel];

		// Pad controls, drive strength taken per port
		st_next.pad_out       = cell_out;
		st_next.pad_oe_n      = cell_oe_n;
		st_next.pad_pullup_en = cell_pu;
		for (int p = 0; p < pioxb_pkg::NPIN; p++) begin
			if (p >= pioxb_pkg::PORT3_BASE) begin
				pidx = 8'd3;
			end else if (p >= pioxb_pkg::PORT2_BASE) begin
				pidx = 8'd2;
			end else if (p >= pioxb_pkg::PORT1_BASE) begin
				pidx = 8'd1;
			end else begin
				pidx = 8'd0;
			end
			st_next.pad_high_drive[p] = st_reg.drive[pidx[1:0]];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.latch    <= pioxb_pkg::LATCH_RST;
			st_reg.inmode   <= pioxb_pkg::INMODE_RST;
			st_reg.outmode  <= pioxb_pkg::OUTMODE_RST;
			st_reg.skip     <= pioxb_pkg::SKIP_RST;
			st_reg.drive    <= pioxb_pkg::DRIVE_RST;
			st_reg.route0   <= pioxb_pkg::ROUTE0_RST;
			st_reg.route1   <= pioxb_pkg::ROUTE1_RST;
			st_reg.route2   <= pioxb_pkg::ROUTE2_RST;
			st_reg.periph_in <= '1;
			st_reg.pad_out  <= '1;
			st_reg.pad_oe_n <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign awready        = st_reg.awready;
	assign wready         = st_reg.wready;
	assign bresp          = st_reg.bresp;
	assign bvalid         = st_reg.bvalid;
	assign arready        = st_reg.arready;
	assign rdata          = st_reg.rdata;
	assign rresp          = st_reg.rresp;
	assign rvalid         = st_reg.rvalid;
	assign periph_in      = st_reg.periph_in;
	assign ext_int_a_level = st_reg.ext_a;
	assign ext_int_b_level = st_reg.ext_b;
	assign pad_out        = st_reg.pad_out;
	assign pad_oe_n       = st_reg.pad_oe_n;
	assign pad_pullup_en  = st_reg.pad_pullup_en;
	assign pad_high_drive = st_reg.pad_high_drive;
endmodule

// ==== verification/pioxb_properties.sv ====
// Purpose: Concurrent checks on the port crossbar block ports
// Assumes: One clock domain, synchronous active low reset
// Notes:   Bound to the top module from the bench top file
`timescale 1ns/1ps
module pioxb_properties (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// Pads
	input wire logic [21:0] pad_out,
	input wire logic [21:0] pad_oe_n,
	input wire logic [21:0] pad_pullup_en,
	input wire logic [21:0] pad_high_drive
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_taken;
		arvalid && arready;
	endsequence

	chk_write_answer: assert property (wr_taken |=> bvalid)
		else $error("write not answered next cycle");
	chk_read_answer: assert property (rd_taken |=> rvalid && !arready)
		else $error("read not answered next cycle");
	chk_bresp_holds: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_rdata_holds: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read data dropped early");
	chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	chk_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read accepted while data pending");
	chk_pullup_low_off: assert property (
		(~pad_oe_n & ~pad_out & pad_pullup_en) == 22'h00_0000)
		else $error("pullup on while pad driven low");
	chk_drive_per_port: assert property (
		pad_high_drive[7:0] inside {8'h00, 8'hFF} &&
		pad_high_drive[15:8] inside {8'h00, 8'hFF} &&
		pad_high_drive[19:16] inside {4'h0, 4'hF} &&
		pad_high_drive[21:20] inside {2'h0, 2'h3})
		else $error("drive strength differs within a port");
	chk_reset_drv_off: assert property (
		$rose(aresetn) |-> &pad_oe_n ##1 (&pad_oe_n && &pad_high_drive))
		else $error("drivers on or low drive after reset");
endmodule

// ==== verification/pioxb_pad_model.sv ====
// Purpose: Board side of the pads: external drivers and loose nets
// Assumes: A strong external driver beats the weak pullup
// Notes:   An undriven net without pullup shows a toggling level
`timescale 1ns/1ps
module pioxb_pad_model (
	// Clock
	input wire logic        aclk,
	// Device pad controls
	input wire logic [21:0] pad_out,
	input wire logic [21:0] pad_oe_n,
	input wire logic [21:0] pad_pullup_en,
	// External drivers
	input wire logic [21:0] ext_en,
	input wire logic [21:0] ext_val,
	// Pad levels
	output logic     [21:0] pad_in
);
	logic [21:0] flt = 22'h15_5555;

	always @(posedge aclk) begin
		flt <= ~flt;
	end
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val) |
		(pad_oe_n & ~ext_en & (pad_pullup_en | flt));
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Register level tests of the port crossbar block
// Assumes: Pad changes settle within four cycles of a write
// Notes:   Placement expectations come from a reference search below
`timescale 1ns/1ps
module tb_top;
	localparam logic [21:0] lat = 22'h2A_5A5A;
	localparam logic [21:0] pp  = 22'h00_07FF;
	localparam logic [23:0] po  = 24'h96_3CA5;
	localparam logic [7:0]  r0 [5] = '{8'h03, 8'h03, 8'h07, 8'hFF, 8'h0C};
	localparam logic [7:0]  r1 [5] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h02};
	localparam logic [7:0]  r2 [5] = '{8'h40, 8'h40, 8'h40, 8'h47, 8'h40};
	localparam logic [19:0] sk [5] = '{20'h0_0008, 20'h0_0008, 20'h0_0008,
		20'h0_0000, 20'h0_00F3};
	localparam logic        fw [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	localparam logic [23:0] en [5] = '{24'h00_003F, 24'h00_001F, 24'h00_00FF,
		24'hFF_FFFF, 24'h00_61C0};
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, spi_four_wire;
	logic        ext_int_a_level, ext_int_b_level;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rd_resp, wr_resp;
	logic [23:0] periph_out, periph_in, exp_in;
	logic [21:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, pad_high_drive;
	logic [21:0] ext_en, ext_val;
	logic [19:0] exp_pl, exp_val;
	int          failures = 0;
	int          compares = 0;

	always #50 aclk = ~aclk;

	pioxb_top u_pioxb_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .periph_out,
		.spi_four_wire, .periph_in, .ext_int_a_level, .ext_int_b_level,
		.pad_in, .pad_out, .pad_oe_n, .pad_pullup_en, .pad_high_drive);
	pioxb_pad_model u_pioxb_pad_model (.aclk, .pad_out, .pad_oe_n,
		.pad_pullup_en, .ext_en, .ext_val, .pad_in);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd_data = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask

	// Reference placement: fixed UART pins, then lowest free pin
	task automatic xb_exp(input logic [23:0] e, input logic [19:0] s);
		logic [19:0] used;
		int p;
		used = s;
		exp_pl = '0;
		exp_val = lat[19:0];
		exp_in = 24'hFF_FFFF;
		for (int i = 0; i < 24; i++) begin
			if (e[i]) begin
				p = 0;
				while (p < 20 && used[p]) p++;
				if (i < 2) p = 4 + i;
				if (p < 20) begin
					used[p] = 1'b1;
					exp_pl[p] = 1'b1;
					exp_val[p] = po[i];
					exp_in[i] = po[i];
				end
			end
		end
	endtask

	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, spi_four_wire, ext_en, ext_val} = '0;
		periph_out = 24'hFF_FFFF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("oe_n_rst", 32'h003F_FFFF, 32'(pad_oe_n));
		rd(pioxb_pkg::OFS_INMODE);
		chk("inmode", 32'h003F_FFFF, rd_data);
		rd(pioxb_pkg::OFS_OUTMODE);
		chk("outmode", 32'h0000_0000, rd_data);
		rd(pioxb_pkg::OFS_DRIVE);
		chk("drive", 32'h0000_000F, rd_data);
		rd(pioxb_pkg::OFS_PORT);
		chk("port_rst", 32'h003F_FFFF, rd_data);
		chk("hidrv_rst", 32'h003F_FFFF, 32'(pad_high_drive));
		rd(6'h28);
		chk("bad_resp", 32'(pioxb_pkg::RESP_SLVERR), 32'(rd_resp));
		chk("bad_data", 32'h0000_0000, rd_data);
		wr(6'h28, 32'hFFFF_FFFF);
		chk("bad_wr", 32'(pioxb_pkg::RESP_SLVERR), 32'(wr_resp));
		wr(pioxb_pkg::OFS_DRIVE, 32'h0000_0005);
		chk("wr_okay", 32'(pioxb_pkg::RESP_OKAY), 32'(wr_resp));
		settle();
		chk("hidrv", 32'h000F_00FF, 32'(pad_high_drive));
		wr(pioxb_pkg::OFS_OUTMODE, 32'(pp));
		wr(pioxb_pkg::OFS_PORT, 32'(lat));
		settle();
		chk("oe_n_off", 32'h003F_FFFF, 32'(pad_oe_n));
		wr(pioxb_pkg::OFS_ROUTE2, 32'h0000_0040);
		settle();
		chk("oe_n_gpio", 32'(~pp & lat), 32'(pad_oe_n));
		chk("out_gpio", 32'(lat), 32'(pad_out));
		chk("pullup", 32'(lat), 32'(pad_pullup_en));
		ext_en <= 22'h20_0000;
		wr(pioxb_pkg::OFS_INMODE, 32'h003F_FFF7);
		settle();
		chk("analog_pad", 32'h2, 32'({pad_oe_n[3], pad_pullup_en[3]}));
		rd(pioxb_pkg::OFS_PORT);
		chk("port_rd", 32'(lat & ~22'h20_0008), rd_data);
		ext_en <= 22'h00_0000;
		wr(pioxb_pkg::OFS_INMODE, 32'h003F_FFFF);
		wr(pioxb_pkg::OFS_ROUTE2, 32'h0000_00C0);
		settle();
		chk("pullup_dis", 32'h0000_0000, 32'(pad_pullup_en));
		periph_out <= po;
		wr(pioxb_pkg::OFS_OUTMODE, 32'h003F_FFFF);
		wr(pioxb_pkg::OFS_EXTINT, 32'h0000_0074);
		for (int i = 0; i < 5; i++) begin
			wr(pioxb_pkg::OFS_SKIP, 32'(sk[i]));
			wr(pioxb_pkg::OFS_ROUTE0, 32'(r0[i]));
			wr(pioxb_pkg::OFS_ROUTE1, 32'(r1[i]));
			wr(pioxb_pkg::OFS_ROUTE2, 32'(r2[i]));
			spi_four_wire <= fw[i];
			settle();
			xb_exp(en[i], sk[i]);
			rd(pioxb_pkg::OFS_ASSIGN);
			chk("placed", 32'(exp_pl), rd_data);
			chk("xbar_out", 32'(exp_val), 32'(pad_out[19:0]));
			chk("p3_out", 32'(lat[21:20]), 32'(pad_out[21:20]));
			chk("periph_in", 32'(exp_in), 32'(periph_in));
			chk("ext_lvl", 32'({exp_val[4], exp_val[7]}),
				32'({ext_int_a_level, ext_int_b_level}));
		end
		end_sim();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		failures++;
		$display("mismatch watchdog expected done seen hang");
		end_sim();
	end
endmodule

bind pioxb_top pioxb_properties u_pioxb_properties (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .pad_out, .pad_oe_n,
	.pad_pullup_en, .pad_high_drive);
